/* verilog/atcs_top.v */
`timescale 1ns/1ps
`include "atcs_regs.vh"
// Notes on behaviour
// - Tracking mode code 01 selects post-tracking.
// - In post and dual tracking a tracking interval starts on convert start and conversion follows it.
// - In post-tracking the sampling switch stays open after a conversion until the next convert start.
// - Tracking mode code 11 selects dual-tracking.
// - In dual-tracking the input is tracked from the end of a conversion until the next one begins.
// - With burst select clear the subsystem clock is the system clock.
// - With burst select set the subsystem clock is the burst oscillator, at most 25 MHz.
// - The SAR clock is the subsystem clock divided by the configuration divider field plus one.
// - The converter is always in exactly one of tracking, converting or idle.
// - In pre-tracking software owns tracking and conversion begins at once on convert start.
// - The tracking interval lasts the tracking time field plus two subsystem cycles.
// - Conversion follows tracking with no idle gap.
// - A conversion takes thirteen SAR cycles plus two subsystem cycles with burst select clear, plus one subsystem cycle with it set.
module atcs_top #(
  parameter TK_W  = `ATCS_TRK_TK_W,
  parameter DIV_W = `ATCS_CFG_SCDIV_W
) (
  input  wire        SYS_CLK_IN,
  input  wire        RESETN_IN,
  input  wire        PSEL_IN,
  input  wire        PENABLE_IN,
  input  wire        PWRITE_IN,
  input  wire [11:0] PADDR_IN,
  input  wire [31:0] PWDATA_IN,
  output reg  [31:0] PRDATA_OUT,
  output reg         PREADY_OUT,
  output reg         PSLVERR_OUT,
  input  wire        CONV_START_IN,
  input  wire        BURST_TICK_IN,
  output reg         TRACKING_OUT,
  output reg         CONVERTING_OUT,
  output reg         IDLE_OUT,
  output reg         SAMPLE_SW_OUT,
  output reg  [5:0]  INPUT_SEL_OUT,
  output reg         BURST_SEL_OUT,
  output reg         CONV_DONE_OUT
);
  localparam ST_IDLE = 3'b001;
  localparam ST_TRK  = 3'b010;
  localparam ST_CONV = 3'b100;
  // Step 0 is the start cycle, 1..13 the SAR cycles, the last one the finish cycle
  localparam integer SAR_LAST  = `ATCS_SAR_CYCLES + 1;
  localparam integer TRK_EXTRA = `ATCS_TRK_EXTRA;
  localparam [7:0]   MUX_RESET = `ATCS_MUX_RESET;

  reg  [7:0]  cfg_q;
  reg  [7:0]  trk_q;
  reg  [5:0]  mux_q;
  reg         swtrk_q;
  reg  [2:0]  st_q;
  reg  [2:0]  st_d;
  reg  [7:0]  cnt_q;
  reg  [7:0]  cnt_d;
  reg  [3:0]  sar_q;
  reg  [3:0]  sar_d;
  reg         done_d;
  reg         start_pend_q;
  reg  [31:0] rdata;
  reg         mapped;
  wire        converter_subsystem_clock_en;
  wire        sar_tick;
  wire        acc;
  wire        wr;
  wire [1:0]  tm;
  wire [TK_W-1:0]  tk;
  wire [DIV_W-1:0] scdiv;
  wire        burst;
  wire        start_req;
  wire        in_idle;
  wire        in_conv;
  wire        rd_first;

  assign acc   = PSEL_IN & PENABLE_IN;
  assign wr    = acc & PWRITE_IN;
  assign tm    = trk_q[`ATCS_TRK_TM_LSB+1:`ATCS_TRK_TM_LSB];
  assign tk    = trk_q[`ATCS_TRK_TK_LSB+TK_W-1:`ATCS_TRK_TK_LSB];
  assign scdiv = cfg_q[`ATCS_CFG_SCDIV_LSB+DIV_W-1:`ATCS_CFG_SCDIV_LSB];
  assign burst = cfg_q[`ATCS_CFG_BURST_BIT];
  // Burst oscillator arrives as an enable pulse; must not exceed 25 MHz
  assign converter_subsystem_clock_en   = burst ? BURST_TICK_IN : 1'b1;
  assign start_req = CONV_START_IN | start_pend_q;
  assign in_idle   = st_q == ST_IDLE;
  assign in_conv   = st_q == ST_CONV;
  assign rd_first  = acc & ~PREADY_OUT & ~PWRITE_IN;

  atcs_sar_clk #(
    .DIV_W (DIV_W)
  ) u_sar_clk (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (RESETN_IN),
    .run_in   (in_conv),
    .en_in    (converter_subsystem_clock_en),
    .div_in   (scdiv),
    .tick_out (sar_tick)
  );

  always @*
  begin
    case (PADDR_IN)
      `ATCS_CFG_OFS:
      begin
        rdata  = {24'h0, cfg_q};
        mapped = 1'b1;
      end
      `ATCS_TRK_OFS:
      begin
        rdata  = {24'h0, trk_q};
        mapped = 1'b1;
      end
      `ATCS_MUX_OFS:
      begin
        rdata  = {26'h0, mux_q};
        mapped = 1'b1;
      end
      `ATCS_CTL_OFS:
      begin
        rdata  = {31'h0, swtrk_q};
        mapped = 1'b1;
      end
      `ATCS_STAT_OFS:
      begin
        rdata  = {28'h0, sar_q[0], st_q};
        mapped = 1'b1;
      end
      default:
      begin
        rdata  = 32'h0;
        mapped = 1'b0;
      end
    endcase
  end

  // Sequencer; one-hot states keep exactly one state active
  always @*
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sar_d  = sar_q;
    done_d = 1'b0;
    case (st_q)
      ST_IDLE:
      begin
        if (start_req && converter_subsystem_clock_en)
        begin
          if (tm == `ATCS_TM_PRE || tm == 2'h2)
          begin
            st_d  = ST_CONV;
            cnt_d = 8'h0;
            sar_d = 4'h0;
          end
          else
          begin
            st_d  = ST_TRK;
            cnt_d = {{(8-TK_W){1'b0}}, tk} + TRK_EXTRA[7:0] - 8'h1;
          end
        end
      end
      ST_TRK:
      begin
        if (converter_subsystem_clock_en)
        begin
          if (cnt_q == 8'h0)
          begin
            st_d  = ST_CONV;
            sar_d = 4'h0;
          end
          else
            cnt_d = cnt_q - 8'h1;
        end
      end
      ST_CONV:
      begin
        // sar_q 0: start cycle, 1..13: SAR cycles, 14: finish cycle
        if (sar_q == 4'h0)
        begin
          if (converter_subsystem_clock_en)
            sar_d = 4'h1;
        end
        else if (sar_q == SAR_LAST[3:0])
        begin
          // A stray tick here must not step past the finish cycle
          if (converter_subsystem_clock_en)
          begin
            st_d   = ST_IDLE;
            done_d = 1'b1;
            sar_d  = 4'h0;
          end
        end
        else if (sar_tick)
          sar_d = sar_q + 4'h1;
      end
      default:
        st_d = ST_IDLE;
    endcase
  end

  // One wait state: answer the cycle after the access phase opens
  always @(posedge SYS_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      PRDATA_OUT  <= 32'h0;
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end
    else
    begin
      PREADY_OUT  <= acc & ~PREADY_OUT;
      PSLVERR_OUT <= acc & ~PREADY_OUT & ~mapped;
      PRDATA_OUT  <= rd_first ? rdata : 32'h0;
    end
  end

  // Writes land on the completing edge; unmapped writes are dropped
  always @(posedge SYS_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      cfg_q   <= `ATCS_CFG_RESET;
      trk_q   <= `ATCS_TRK_RESET;
      mux_q   <= MUX_RESET[5:0];
      swtrk_q <= 1'b0;
    end
    else if (wr && PREADY_OUT)
    begin
      case (PADDR_IN)
        `ATCS_CFG_OFS:
        begin
          cfg_q <= PWDATA_IN[7:0];
        end
        `ATCS_TRK_OFS:
        begin
          trk_q <= {2'h0, PWDATA_IN[5:0]};
        end
        `ATCS_MUX_OFS:
        begin
          mux_q <= PWDATA_IN[5:0];
        end
        `ATCS_CTL_OFS:
        begin
          swtrk_q <= PWDATA_IN[0];
        end
        default:
        begin
          swtrk_q <= swtrk_q;
        end
      endcase
    end
  end

  // Sequencer state and counters
  always @(posedge SYS_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      st_q         <= ST_IDLE;
      cnt_q        <= 8'h0;
      sar_q        <= 4'h0;
      start_pend_q <= 1'b0;
    end
    else
    begin
      // A start between burst ticks waits for the next tick; starts while busy are dropped
      start_pend_q <= start_req & in_idle & ~converter_subsystem_clock_en;
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      sar_q        <= sar_d;
    end
  end

  // Pins follow the next state so they line up with st_q
  always @(posedge SYS_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      TRACKING_OUT   <= 1'b0;
      CONVERTING_OUT <= 1'b0;
      IDLE_OUT       <= 1'b1;
      SAMPLE_SW_OUT  <= 1'b0;
      INPUT_SEL_OUT  <= MUX_RESET[5:0];
      BURST_SEL_OUT  <= 1'b0;
      CONV_DONE_OUT  <= 1'b0;
    end
    else
    begin
      TRACKING_OUT   <= st_d == ST_TRK;
      CONVERTING_OUT <= st_d == ST_CONV;
      IDLE_OUT       <= st_d == ST_IDLE;
      // Switch closed while tracking; pre-mode lets software hold it
      SAMPLE_SW_OUT  <= (st_d == ST_TRK) |
                        (st_d == ST_IDLE && tm == `ATCS_TM_DUAL) |
                        (st_d == ST_IDLE && tm != `ATCS_TM_POST && tm != `ATCS_TM_DUAL && swtrk_q);
      INPUT_SEL_OUT  <= mux_q;
      BURST_SEL_OUT  <= burst;
      CONV_DONE_OUT  <= done_d;
    end
  end
endmodule

/* verilog/atcs_regs.vh */
`ifndef ATCS_REGS_VH
`define ATCS_REGS_VH
// Register byte offsets
`define ATCS_CFG_OFS       12'h000
`define ATCS_TRK_OFS       12'h004
`define ATCS_MUX_OFS       12'h008
`define ATCS_CTL_OFS       12'h00c
`define ATCS_STAT_OFS      12'h010
// Configuration register fields
`define ATCS_CFG_SCDIV_LSB 3
`define ATCS_CFG_SCDIV_W   5
`define ATCS_CFG_BURST_BIT 0
`define ATCS_CFG_RESET     8'hf8
// Tracking register fields
`define ATCS_TRK_TK_LSB    0
`define ATCS_TRK_TK_W      4
`define ATCS_TRK_TM_LSB    4
`define ATCS_TRK_RESET     8'h0f
// Input select
`define ATCS_MUX_W         6
`define ATCS_MUX_RESET     8'h3f
// Tracking mode codes
`define ATCS_TM_PRE        2'h0
`define ATCS_TM_POST       2'h1
`define ATCS_TM_DUAL       2'h3
// Fixed cycle figures
`define ATCS_TRK_EXTRA     2
`define ATCS_SAR_CYCLES    13
`define ATCS_CONV_EXTRA    2
`define ATCS_BURST_MAX_MHZ 25
`endif

/* verilog/atcs_sar_clk.v */
`timescale 1ns/1ps
module atcs_sar_clk #(
  parameter DIV_W = 5
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             run_in,
  input  wire             en_in,
  input  wire [DIV_W-1:0] div_in,
  output reg              tick_out
);
  reg [DIV_W-1:0] cnt_q;

  // Tick after every div_in+1 subsystem cycles; phase restarts with each conversion
  // Counting only on subsystem cycles keeps the ratio right under the burst clock
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q    <= {DIV_W{1'b0}};
      tick_out <= 1'b0;
    end
    else if (!run_in)
    begin
      cnt_q    <= {DIV_W{1'b0}};
      tick_out <= 1'b0;
    end
    else if (!en_in)
    begin
      cnt_q    <= cnt_q;
      tick_out <= 1'b0;
    end
    else if (cnt_q == div_in)
    begin
      cnt_q    <= {DIV_W{1'b0}};
      tick_out <= 1'b1;
    end
    else
    begin
      cnt_q    <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
      tick_out <= 1'b0;
    end
  end
endmodule

/* dv/atcs_top_props.sv */
`timescale 1ns/1ps
module atcs_top_props (
  input wire        SYS_CLK_IN, RESETN_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT,
  input wire [11:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  input wire        TRACKING_OUT, CONVERTING_OUT, IDLE_OUT, SAMPLE_SW_OUT, BURST_SEL_OUT, CONV_DONE_OUT
);
  reg  [7:0] cfg_q;
  reg  [7:0] trk_q;
  reg  [8:0] t_n;
  reg  [8:0] c_n;
  wire       wr = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
  // Shadow of mode and timing fields, snooped from the bus
  always @(posedge SYS_CLK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      cfg_q <= 8'hf8;
      trk_q <= 8'h0f;
      t_n   <= 9'h0;
      c_n   <= 9'h0;
    end
    else
    begin
      cfg_q <= (wr && PADDR_IN == 12'h000) ? PWDATA_IN[7:0] : cfg_q;
      trk_q <= (wr && PADDR_IN == 12'h004) ? PWDATA_IN[7:0] : trk_q;
      t_n   <= TRACKING_OUT ? t_n + 9'h1 : 9'h0;
      c_n   <= CONVERTING_OUT ? c_n + 9'h1 : 9'h0;
    end
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  state_onehot_a: assert property ($onehot({TRACKING_OUT, CONVERTING_OUT, IDLE_OUT}))
    else $error("state not one-hot");
  start_path_a: assert property ($fell(IDLE_OUT) |-> (trk_q[4] ? TRACKING_OUT : CONVERTING_OUT))
    else $error("wrong first state");
  trk_len_a: assert property ($fell(TRACKING_OUT) && !BURST_SEL_OUT |-> t_n == trk_q[3:0] + 2)
    else $error("tracking length");
  no_gap_a: assert property ($fell(TRACKING_OUT) |-> CONVERTING_OUT)
    else $error("gap after tracking");
  conv_len_a: assert property ($fell(CONVERTING_OUT) && !BURST_SEL_OUT |-> c_n == 13 * (cfg_q[7:3] + 1) + 2)
    else $error("conversion length");
  done_at_end_a: assert property (CONV_DONE_OUT |-> IDLE_OUT && $past(CONVERTING_OUT))
    else $error("done out of place");
  post_open_a: assert property (IDLE_OUT && trk_q[5:4] == 2'h1 |-> !SAMPLE_SW_OUT)
    else $error("switch closed when idle");
  dual_track_a: assert property ($rose(IDLE_OUT) && trk_q[5:4] == 2'h3 |=> SAMPLE_SW_OUT)
    else $error("no tracking after conversion");
  apb_ready_a: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
    else $error("ready late");
endmodule
bind atcs_top atcs_top_props u_atcs_top_props (.SYS_CLK_IN, .RESETN_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
  .PREADY_OUT, .PADDR_IN, .PWDATA_IN, .TRACKING_OUT, .CONVERTING_OUT, .IDLE_OUT, .SAMPLE_SW_OUT,
  .BURST_SEL_OUT, .CONV_DONE_OUT);

/* dv/atcs_trig_model.sv */
`timescale 1ns/1ps
module atcs_trig_model (
  input  wire clk_in,
  input  wire fire_in,
  input  wire burst_in,
  output reg  start_out = 1'b0,
  output reg  tick_out = 1'b0
);
  reg [1:0] ph_q = 2'h0;
  // Burst oscillator slower than the bus clock, so a start may wait for a tick
  always @(posedge clk_in)
  begin
    ph_q      <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    tick_out  <= burst_in && ph_q == 2'h0;
    start_out <= fire_in;
  end
endmodule

/* dv/adc_track_convert_sequencer_test.sv */
`timescale 1ns/1ps
`include "atcs_regs.vh"
module adc_track_convert_sequencer_test;
  reg         clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, fire = 1'b0, err;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire        pready, pslverr, start, tick, trk, cnv, idle, sw, bsel, done;
  wire [5:0]  isel;
  integer     err_total = 0, num_checks = 0;
  always #50 clk = ~clk;
  atcs_top u_atcs_top (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .CONV_START_IN(start), .BURST_TICK_IN(tick), .TRACKING_OUT(trk), .CONVERTING_OUT(cnv), .IDLE_OUT(idle),
    .SAMPLE_SW_OUT(sw), .INPUT_SEL_OUT(isel), .BURST_SEL_OUT(bsel), .CONV_DONE_OUT(done));
  atcs_trig_model u_atcs_trig_model (.clk_in(clk), .fire_in(fire), .burst_in(bsel), .start_out(start),
    .tick_out(tick));
  task tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task chk(input [8*8-1:0] what, input [31:0] seen, input [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("wrong value %0s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  // Request held until pready is seen high at a rising edge; data taken there
  task apb(input w, input [11:0] a, input [31:0] d);
    integer i;
  begin
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    i = 0;
    @(posedge clk);
    while (i < 20 && pready !== 1'b1)
    begin
      i = i + 1;
      @(posedge clk);
    end
    if (i == 20)
    begin
      err_total = err_total + 1;
      tally_and_finish;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  end
  endtask
  task conv(output integer nt);
    integer i;
  begin
    @(posedge clk) fire <= 1'b1;
    @(posedge clk) fire <= 1'b0;
    nt = 0;
    for (i = 0; i < 2000 && done !== 1'b1; i = i + 1)
    begin
      @(negedge clk);
      nt = nt + (trk === 1'b1);
    end
    chk("done", {done, idle}, 32'h3);
    if (i == 2000)
      tally_and_finish;
  end
  endtask
  task s_regs;
  begin
    apb(0, `ATCS_MUX_OFS, 32'h0);
    chk("mux_rst", rd, 32'h3f);
    apb(0, `ATCS_CFG_OFS, 32'h0);
    chk("cfg_rst", rd, 32'hf8);
    apb(0, 12'h020, 32'h0);
    chk("unm_err", err, 32'h1);
    chk("unm_rd", rd, 32'h0);
    apb(1, `ATCS_MUX_OFS, 32'hd2);
    apb(0, `ATCS_MUX_OFS, 32'h0);
    chk("mux_rd", rd, 32'h12);
    chk("mux_pin", isel, 32'h12);
  end
  endtask
  task s_post;
    integer nt;
  begin
    apb(1, `ATCS_TRK_OFS, 32'h13);
    conv(nt);
    chk("trk_len", nt, 32'h5);
    @(negedge clk) chk("sw_open", sw, 32'h0);
  end
  endtask
  task s_dual;
    integer nt;
  begin
    apb(1, `ATCS_CFG_OFS, 32'h08);
    apb(1, `ATCS_TRK_OFS, 32'h30);
    conv(nt);
    chk("trk_len", nt, 32'h2);
    @(negedge clk) chk("sw_track", sw, 32'h1);
  end
  endtask
  task s_pre_burst;
    integer nt;
  begin
    apb(1, `ATCS_TRK_OFS, 32'h00);
    conv(nt);
    chk("pre_trk", nt, 32'h0);
    apb(1, `ATCS_CFG_OFS, 32'h01);
    repeat (2) @(negedge clk);
    chk("burst", bsel, 32'h1);
    conv(nt);
    chk("pre_brst", nt, 32'h0);
  end
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    s_regs;
    s_post;
    s_dual;
    s_pre_burst;
    tally_and_finish;
  end
endmodule
